// file: bsp_pkg.sv
/*
 * bsp_pkg: constants and carrier types for the boot section protection block.
 * Assumes a 100 MHz system clock and a word-addressed program memory.
 */
package bsp_pkg;
    localparam int unsigned BSP_ADDR_W = 16;
    localparam logic [15:0] BSP_APP_RESET_ADDR = 16'h0000;
    localparam logic [15:0] BSP_BOOT_START_RESET = 16'hf000;
    localparam logic [1:0] BSP_FUSE_RESET = 2'h3;
    localparam logic [31:0] BSP_ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] BSP_ADDR_LOCK = 32'h0000_0004;
    localparam logic [31:0] BSP_ADDR_FUSE = 32'h0000_0008;
    localparam logic [31:0] BSP_ADDR_VECTOR = 32'h0000_000c;
    localparam logic [31:0] BSP_ADDR_STATUS = 32'h0000_0010;
    localparam logic [31:0] BSP_ADDR_BOUND = 32'h0000_0014;
    localparam int unsigned BSP_CTRL_IVSEL_BIT = 0;
    localparam int unsigned BSP_CTRL_PROG_BIT = 1;
    localparam int unsigned BSP_CTRL_ERASE_BIT = 2;
    localparam int unsigned BSP_FUSE_BOOT_RESET_FUSE_BIT = 0;
    localparam int unsigned BSP_FUSE_HW_BOOT_ENABLE_FUSE_BIT = 1;
    localparam logic [1:0] BSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] BSP_RESP_SLVERR = 2'h2;
    localparam logic [1:0] BSP_LOCK_MODE1 = 2'h3;
    localparam logic [1:0] BSP_LOCK_MODE2 = 2'h2;
    localparam logic [1:0] BSP_LOCK_MODE3 = 2'h0;
    localparam logic [1:0] BSP_LOCK_MODE4 = 2'h1;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] addr;
        logic wr;
        logic rd;
    } bsp_access_s;

    typedef struct packed {
        logic [1:0] app_pair;
        logic [1:0] boot_pair;
    } bsp_locks_s;
endpackage : bsp_pkg

// file: bsp_protect.sv
/*
 * bsp_protect: lock bit checks on self-programming writes and program memory
 * reads, interrupt suppression, and reset vector selection, with an
 * AXI4-Lite register port for software and programming-mode access.
 * Assumes the core presents one access per cycle and fuse values come from
 * the programming interface only.
 */
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
// Overview of operation
// - a stored 1 means unprogrammed, a stored 0 means programmed
// - lock bits only go programmed by writes; chip erase restores unprogrammed
// - general memory lock modes never affect core writes or reads
// - application pair 11: all application writes and reads allowed
// - application pair 10: writes blocked, reads allowed
// - application pair 00: writes blocked, reads from boot section blocked
// - application pair 01: writes allowed, reads from boot section blocked
// - application modes 3,4, vectors in boot: interrupts off in application
// - boot pair 11: all boot section writes and reads allowed
// - boot pair 10: writes blocked, reads allowed
// - boot pair 00: writes blocked, reads from application blocked
// - boot pair 01: writes allowed, reads from application blocked
// - boot modes 3,4, vectors in application: interrupts off in boot
// - reset fuse 1 starts at 0x0000, 0 at boot loader address
// - the core can never change a fuse
// - hardware boot pin counts only when its enable fuse is programmed
// - pin is an input during reset, sampled at reset release
// - pin low at reset release forces the boot loader vector
`timescale 1ns/1ps
`default_nettype none
module bsp_protect (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire bsp_pkg::bsp_access_s access_in,
    input wire logic [15:0] access_wdata_in,
    input wire logic hw_boot_pin_in,
    output logic hw_boot_pin_out,
    output logic hw_boot_pin_oe_out,
    input wire logic prog_mode_in,
    output logic flash_we_out,
    output logic [15:0] flash_addr_out,
    output logic [15:0] flash_wdata_out,
    output logic flash_re_out,
    output logic read_blocked_out,
    output logic write_blocked_out,
    output logic irq_suppress_out,
    output logic [15:0] reset_vector_out,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import bsp_pkg::*;

    logic app_lock_bit_hi;
    logic app_lock_bit_lo;
    logic boot_lock_bit_hi;
    logic boot_lock_bit_lo;
    logic boot_reset_fuse;
    logic hw_boot_enable_fuse;
    logic vectors_in_boot;
    logic [15:0] boot_start;
    logic in_reset_d;
    logic hw_boot_pin_low;
    logic hw_boot_forced;
    logic [1:0] app_section_lock_pair;
    logic [1:0] boot_section_lock_pair;
    logic pc_in_boot;
    logic target_in_boot;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_held;
    logic w_held;
    logic do_write;
    logic [1:0] next_bresp;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic write_blocked;
    logic read_blocked;

    assign app_section_lock_pair = {app_lock_bit_hi, app_lock_bit_lo};
    assign boot_section_lock_pair = {boot_lock_bit_hi, boot_lock_bit_lo};

    // section split: everything at or above boot_start is the boot loader
    assign pc_in_boot = access_in.pc >= boot_start;
    assign target_in_boot = access_in.addr >= boot_start;

    // only the boot and application lock pairs decide; no general memory lock is consulted
    always_comb begin
        wr_ok = 1'b1;
        rd_ok = 1'b1;
        if (target_in_boot) begin
            unique case (boot_section_lock_pair)
                BSP_LOCK_MODE1: begin
                    wr_ok = 1'b1;
                end
                BSP_LOCK_MODE2: begin
                    wr_ok = 1'b0;
                end
                BSP_LOCK_MODE3: begin
                    wr_ok = 1'b0;
                    rd_ok = pc_in_boot;
                end
                BSP_LOCK_MODE4: begin
                    rd_ok = pc_in_boot;
                end
            endcase
        end else begin
            unique case (app_section_lock_pair)
                BSP_LOCK_MODE1: begin
                    wr_ok = 1'b1;
                end
                BSP_LOCK_MODE2: begin
                    wr_ok = 1'b0;
                end
                BSP_LOCK_MODE3: begin
                    wr_ok = 1'b0;
                    rd_ok = !pc_in_boot;
                end
                BSP_LOCK_MODE4: begin
                    rd_ok = !pc_in_boot;
                end
            endcase
        end
    end

    // a refused access still shows on its own strobe so the core can see it
    assign write_blocked = access_in.wr && !wr_ok;
    assign read_blocked = access_in.rd && !rd_ok;

    // blocked accesses never reach the flash array
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flash_we_out <= 1'b0;
            flash_re_out <= 1'b0;
            flash_addr_out <= 16'h0000;
            flash_wdata_out <= 16'h0000;
            write_blocked_out <= 1'b0;
            read_blocked_out <= 1'b0;
        end else if (clk_en_in) begin
            flash_we_out <= access_in.wr && wr_ok;
            flash_re_out <= access_in.rd && rd_ok;
            flash_addr_out <= access_in.addr;
            flash_wdata_out <= access_wdata_in;
            write_blocked_out <= write_blocked;
            read_blocked_out <= read_blocked;
        end
    end

    // interrupt masking while running in the section locked against the vectors
    // modes 3 and 4 share a programmed high bit, which is all this needs
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq_suppress_out <= 1'b0;
        end else if (clk_en_in) begin
            irq_suppress_out <=
                (vectors_in_boot && !pc_in_boot && !app_lock_bit_hi)
                || (!vectors_in_boot && pc_in_boot && !boot_lock_bit_hi);
        end
    end

    // pin is never driven: enable high means released, pin stays an input
    assign hw_boot_pin_out = 1'b0;
    assign hw_boot_pin_oe_out = 1'b1;

    // catch the pin at the first enabled edge after reset release
    // only the low level is remembered; the enable fuse gates it live, since the
    // fuse copy here is rebuilt by reset and would otherwise never be programmed
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            in_reset_d <= 1'b1;
            hw_boot_pin_low <= 1'b0;
        end else if (clk_en_in) begin
            in_reset_d <= 1'b0;
            if (in_reset_d) begin
                hw_boot_pin_low <= !hw_boot_pin_in;
            end
        end
    end

    // pin counts only while its enable fuse is programmed
    assign hw_boot_forced = hw_boot_pin_low && !hw_boot_enable_fuse;

    // fuses are re-read every cycle, so a fuse write in programming mode
    // moves the vector at once instead of after the next reset

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            reset_vector_out <= BSP_APP_RESET_ADDR;
        end else if (clk_en_in) begin
            if (hw_boot_forced || !boot_reset_fuse) begin
                reset_vector_out <= boot_start;
            end else begin
                reset_vector_out <= BSP_APP_RESET_ADDR;
            end
        end
    end

    // AXI4-Lite write path
    // address and data may come in either order; each is held until both are in
    // ready stays low while a response waits, so only one write is under way
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (clk_en_in) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // unmapped offsets answer with an error and change nothing
    always_comb begin
        next_bresp = BSP_RESP_SLVERR;
        unique case (aw_addr)
            BSP_ADDR_CTRL, BSP_ADDR_LOCK, BSP_ADDR_FUSE, BSP_ADDR_BOUND: begin
                next_bresp = BSP_RESP_OKAY;
            end
            BSP_ADDR_VECTOR, BSP_ADDR_STATUS: begin
                next_bresp = BSP_RESP_OKAY;
            end
            default: begin
                next_bresp = BSP_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= BSP_RESP_OKAY;
        end else if (clk_en_in) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= next_bresp;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // lock bits: writes may only program (clear) bits; erase restores ones
    // an and-write means software can tighten a section but never unlock it
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            app_lock_bit_hi <= 1'b1;
            app_lock_bit_lo <= 1'b1;
            boot_lock_bit_hi <= 1'b1;
            boot_lock_bit_lo <= 1'b1;
        end else if (clk_en_in && do_write && w_strb[0]) begin
            if (aw_addr == BSP_ADDR_CTRL && prog_mode_in && w_data[BSP_CTRL_ERASE_BIT]) begin
                app_lock_bit_hi <= 1'b1;
                app_lock_bit_lo <= 1'b1;
                boot_lock_bit_hi <= 1'b1;
                boot_lock_bit_lo <= 1'b1;
            end else if (aw_addr == BSP_ADDR_LOCK) begin
                app_lock_bit_lo <= app_lock_bit_lo & w_data[0];
                app_lock_bit_hi <= app_lock_bit_hi & w_data[1];
                boot_lock_bit_lo <= boot_lock_bit_lo & w_data[2];
                boot_lock_bit_hi <= boot_lock_bit_hi & w_data[3];
            end
        end
    end

    // fuses and section boundary change only in programming mode
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            boot_reset_fuse <= BSP_FUSE_RESET[BSP_FUSE_BOOT_RESET_FUSE_BIT];
            hw_boot_enable_fuse <= BSP_FUSE_RESET[BSP_FUSE_HW_BOOT_ENABLE_FUSE_BIT];
            boot_start <= BSP_BOOT_START_RESET;
        end else if (clk_en_in && do_write && prog_mode_in) begin
            if (aw_addr == BSP_ADDR_FUSE && w_strb[0]) begin
                boot_reset_fuse <= w_data[BSP_FUSE_BOOT_RESET_FUSE_BIT];
                hw_boot_enable_fuse <= w_data[BSP_FUSE_HW_BOOT_ENABLE_FUSE_BIT];
            end
            if (aw_addr == BSP_ADDR_BOUND && w_strb[1:0] == 2'h3) begin
                boot_start <= w_data[15:0];
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            vectors_in_boot <= 1'b0;
        end else if (clk_en_in && do_write && aw_addr == BSP_ADDR_CTRL && w_strb[0]) begin
            vectors_in_boot <= w_data[BSP_CTRL_IVSEL_BIT];
        end
    end

    // AXI4-Lite read path
    // a new address is taken only once the last read data has been accepted
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = BSP_RESP_OKAY;
        unique case (s_axi_araddr)
            BSP_ADDR_CTRL: begin
                next_rdata = {29'h0000_0000, 1'b0, prog_mode_in, vectors_in_boot};
            end
            BSP_ADDR_LOCK: begin
                next_rdata = {28'h000_0000, boot_section_lock_pair, app_section_lock_pair};
            end
            BSP_ADDR_FUSE: begin
                next_rdata = {30'h0000_0000, hw_boot_enable_fuse, boot_reset_fuse};
            end
            BSP_ADDR_VECTOR: begin
                next_rdata = {16'h0000, reset_vector_out};
            end
            BSP_ADDR_STATUS: begin
                next_rdata = {28'h000_0000, hw_boot_forced, irq_suppress_out,
                              write_blocked_out, read_blocked_out};
            end
            BSP_ADDR_BOUND: begin
                next_rdata = {16'h0000, boot_start};
            end
            default: begin
                next_rresp = BSP_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= BSP_RESP_OKAY;
        end else if (clk_en_in) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : bsp_protect
`default_nettype wire

// file: bsp_protect_chk.sv
/* bsp_protect_chk: port-level assertions for bsp_protect.
   Assumes the boot section start stays at its reset value. */
`timescale 1ns/1ps
`default_nettype none
module bsp_protect_chk (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire bsp_pkg::bsp_access_s access_in,
    input wire logic hw_boot_pin_oe_out,
    input wire logic flash_we_out,
    input wire logic flash_re_out,
    input wire logic write_blocked_out,
    input wire logic read_blocked_out,
    input wire logic [15:0] flash_addr_out,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import bsp_pkg::*;
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence wr_take;
        clk_en_in && access_in.wr;
    endsequence
    sequence rd_take;
        clk_en_in && access_in.rd;
    endsequence
    one_write_result_a: assert property (wr_take |=> flash_we_out != write_blocked_out)
        else $error("write access without a single outcome");
    one_read_result_a: assert property (rd_take |=> flash_re_out != read_blocked_out)
        else $error("read access without a single outcome");
    idle_no_strobe_a: assert property (clk_en_in && !access_in.wr && !access_in.rd |=>
        !(flash_we_out || flash_re_out || write_blocked_out || read_blocked_out))
        else $error("strobe without access");
    own_read_ok_a: assert property (rd_take and ((access_in.pc >= BSP_BOOT_START_RESET) ==
        (access_in.addr >= BSP_BOOT_START_RESET)) |=> flash_re_out)
        else $error("read within own section refused");
    addr_copy_a: assert property ((wr_take or rd_take) |=> flash_addr_out == $past(access_in.addr))
        else $error("flash address not the access target");
    pin_input_a: assert property (disable iff (1'h0) hw_boot_pin_oe_out)
        else $error("boot pin driven");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped early");
    unmapped_read_a: assert property (clk_en_in && s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > BSP_ADDR_BOUND |=> s_axi_rresp == BSP_RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule : bsp_protect_chk
bind bsp_protect bsp_protect_chk chk (.*);
`default_nettype wire

// file: bsp_core_model.sv
/* bsp_core_model: processor core issuing program memory accesses.
   Assumes calls come from the block's clock domain. */
`timescale 1ns/1ps
`default_nettype none
module bsp_core_model (
    input wire logic clock_in,
    output var bsp_pkg::bsp_access_s access_out,
    output logic [15:0] wdata_out
);
    import bsp_pkg::*;
    initial begin
        access_out = '0;
        wdata_out = 16'h0000;
    end
    // one access, then idle with every address bit flipped
    task automatic issue(input logic [15:0] pc, input logic [15:0] addr, input logic wr, input logic rd);
        @(posedge clock_in);
        access_out <= '{pc: pc, addr: addr, wr: wr, rd: rd};
        wdata_out <= ~addr;
        @(posedge clock_in);
        access_out <= '{pc: ~pc, addr: ~addr, wr: 1'h0, rd: 1'h0};
        wdata_out <= addr;
    endtask : issue
endmodule : bsp_core_model
`default_nettype wire

// file: bsp_protect_tb.sv
/* bsp_protect_tb: self-checking bench for bsp_protect with a core model.
   Assumes a 100 MHz clock and the boot section start at its reset value. */
`timescale 1ns/1ps
`default_nettype none
module bsp_protect_tb;
    import bsp_pkg::*;
    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    logic clk_en_in = 1'h1;
    logic prog_mode_in = 1'h0;
    logic pin_drv = 1'h1;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic flash_we_out, flash_re_out, write_blocked_out, read_blocked_out, irq_suppress_out;
    logic hw_boot_pin_out, hw_boot_pin_oe_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [15:0] flash_addr_out, flash_wdata_out, reset_vector_out, access_wdata_in;
    bsp_access_s access_in;
    int fails = 0;
    int checks = 0;
    wire logic hw_boot_pin_in = hw_boot_pin_oe_out ? pin_drv : hw_boot_pin_out;
    always #5 clock_in = ~clock_in;
    bsp_core_model core (.clock_in(clock_in), .access_out(access_in), .wdata_out(access_wdata_in));
    bsp_protect dut (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        bit b_ok;
        int n;
        @(posedge clock_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        n = 0;
        b_ok = 1'h0;
        while (!b_ok && n < 100) begin
            @(negedge clock_in);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid;
            r = s_axi_bresp;
            n++;
            @(posedge clock_in);
            if (aw_ok) s_axi_awvalid <= 1'h0;
            if (w_ok) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        if (!b_ok) fails++;
    endtask : axw
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_ok;
        bit r_ok;
        int n;
        @(posedge clock_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        n = 0;
        r_ok = 1'h0;
        while (!r_ok && n < 100) begin
            @(negedge clock_in);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            n++;
            @(posedge clock_in);
            if (ar_ok) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        if (!r_ok) fails++;
    endtask : axr
    task automatic do_reset();
        rst_in <= 1'h1;
        repeat (3) @(posedge clock_in);
        rst_in <= 1'h0;
        repeat (4) @(posedge clock_in);
    endtask : do_reset
    task automatic t_reset_values();
        @(negedge clock_in);
        chk(reset_vector_out, BSP_APP_RESET_ADDR);
        axr(BSP_ADDR_LOCK, rd, resp);
        chk(rd[3:0], 4'hf);
        axr(BSP_ADDR_FUSE, rd, resp);
        chk(rd[1:0], BSP_FUSE_RESET);
        $display("test reset_values done");
    endtask : t_reset_values
    task automatic t_lock_modes();
        logic [1:0] pairs [4] = '{BSP_LOCK_MODE1, BSP_LOCK_MODE2, BSP_LOCK_MODE3, BSP_LOCK_MODE4};
        logic [1:0] p;
        logic [3:0] lk;
        logic [15:0] tgt, own, oth;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 4; k++) begin
                p = pairs[k];
                lk = (s == 1) ? {p, 2'h3} : {2'h3, p};
                tgt = (s == 1) ? 16'hf800 : 16'h0400;
                own = (s == 1) ? 16'hf900 : 16'h0500;
                oth = (s == 1) ? 16'h0200 : 16'hf100;
                prog_mode_in <= 1'h1;
                axw(BSP_ADDR_CTRL, 32'h4, resp);
                prog_mode_in <= 1'h0;
                axw(BSP_ADDR_CTRL, (s == 0) ? 32'h1 : 32'h0, resp);
                axw(BSP_ADDR_LOCK, {28'h0, lk}, resp);
                axw(BSP_ADDR_LOCK, 32'hf, resp);
                axr(BSP_ADDR_LOCK, rd, resp);
                chk(rd[3:0], lk);
                core.issue(16'hf100, tgt, 1'h1, 1'h0);
                @(negedge clock_in);
                chk({flash_we_out, write_blocked_out}, {p[0], ~p[0]});
                chk(flash_wdata_out, tgt ^ 16'hffff);
                core.issue(oth, tgt, 1'h0, 1'h1);
                @(negedge clock_in);
                chk({flash_re_out, read_blocked_out}, {p[1], ~p[1]});
                core.issue(own, tgt, 1'h0, 1'h1);
                @(negedge clock_in);
                chk({flash_re_out, irq_suppress_out}, {1'h1, ~p[1]});
            end
        end
        $display("test lock_modes done");
    endtask : t_lock_modes
    task automatic t_fuses();
        axw(BSP_ADDR_FUSE, 32'h0, resp);
        axr(BSP_ADDR_FUSE, rd, resp);
        chk(rd[1:0], 2'h3);
        prog_mode_in <= 1'h1;
        axw(BSP_ADDR_FUSE, 32'h2, resp);
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        chk(reset_vector_out, BSP_BOOT_START_RESET);
        axr(BSP_ADDR_VECTOR, rd, resp);
        chk(rd[15:0], BSP_BOOT_START_RESET);
        axw(BSP_ADDR_FUSE, 32'h3, resp);
        prog_mode_in <= 1'h0;
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        chk(reset_vector_out, BSP_APP_RESET_ADDR);
        $display("test fuses done");
    endtask : t_fuses
    task automatic t_hw_boot();
        @(posedge clock_in);
        pin_drv <= 1'h0;
        do_reset();
        @(negedge clock_in);
        chk(reset_vector_out, BSP_APP_RESET_ADDR);
        @(posedge clock_in);
        pin_drv <= 1'h1;
        prog_mode_in <= 1'h1;
        axw(BSP_ADDR_FUSE, 32'h1, resp);
        repeat (3) @(posedge clock_in);
        @(negedge clock_in);
        chk(reset_vector_out, BSP_BOOT_START_RESET);
        axr(BSP_ADDR_STATUS, rd, resp);
        chk(rd[3], 1'h1);
        axw(BSP_ADDR_FUSE, 32'h3, resp);
        prog_mode_in <= 1'h0;
        axr(32'h0000_0040, rd, resp);
        chk(resp, BSP_RESP_SLVERR);
        axw(32'h0000_0040, 32'h0, resp);
        chk(resp, BSP_RESP_SLVERR);
        axr(BSP_ADDR_LOCK, rd, resp);
        chk(rd[3:0], 4'hf);
        $display("test hw_boot done");
    endtask : t_hw_boot
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        do_reset();
        t_reset_values();
        t_lock_modes();
        t_fuses();
        t_hw_boot();
        report_and_stop();
    end
    initial begin
        #100us;
        fails++;
        report_and_stop();
    end
endmodule : bsp_protect_tb
`default_nettype wire
